// file: rtl/cpwm_defines.svh
// Offsets, field positions, reset values and counts of the complementary PWM channel
`ifndef CPWM_DEFINES_SVH
`define CPWM_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CPWM_ADDR_CTRL 8'h00
`define CPWM_ADDR_DUTY 8'h04
`define CPWM_ADDR_DEAD 8'h08
`define CPWM_ADDR_CAPTOP 8'h0c
`define CPWM_ADDR_STATUS 8'h10
`define CPWM_ADDR_MASK 8'h14
`define CPWM_ADDR_COUNT 8'h18
`define CPWM_ADDR_ACTIVE 8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CPWM_CTRL_RUN 0
`define CPWM_CTRL_CAPTOP 1
`define CPWM_ST_OVF 0
`define CPWM_ST_CAP 1
`define CPWM_COUNT_UP 16

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CPWM_TOP8 16'h00ff
`define CPWM_PERIOD8 (2 * `CPWM_TOP8)
`define CPWM_CAPTOP_RST 16'h00ff
`define CPWM_DUTY_RST 16'h0080
`define CPWM_DEAD_RST 16'h0000
`define CPWM_TOP_MIN 16'h0001

`endif

// file: rtl/cpwm_pkg.sv
// Types shared by the complementary PWM channel
`include "cpwm_defines.svh"
package cpwm_pkg;

   // ----------------------------------------
   // Top value source
   // ----------------------------------------
   typedef enum logic {CPWM_TOP_FIXED8, CPWM_TOP_CAPTURE} cpwm_top_e;

   // ----------------------------------------
   // Bus request and compare pair
   // ----------------------------------------
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } cpwm_avm_req_s;

   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
   } cpwm_cmp_s;

endpackage

// file: rtl/cpwm_updown.sv
// Dual-slope up/down counter for the complementary PWM channel
`timescale 1ns/1ps
module cpwm_updown #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_run,
   input wire logic [W-1:0] i_top,
   // Count state
   output logic [W-1:0] o_count,
   output logic o_up,
   output logic o_at_top,
   output logic o_at_bottom
);

   // ----------------------------------------
   // Triangle count: 2*top states per cycle
   // ----------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_count <= '0;
         o_up <= 1'b1;
      end
      else if (!i_run)
      begin
         o_count <= '0;
         o_up <= 1'b1;
      end
      else if (o_up)
      begin
         if (o_count >= i_top)
         begin
            o_count <= o_count - 1'b1;
            o_up <= 1'b0;
         end
         else
         begin
            o_count <= o_count + 1'b1;
         end
      end
      else if (o_count == '0)
      begin
         o_count <= o_count + 1'b1;
         o_up <= 1'b1;
      end
      else
      begin
         o_count <= o_count - 1'b1;
      end
   end

   // Top must be at least one, or the turn at top wraps
   assign o_at_top = i_run & o_up & (o_count >= i_top);
   assign o_at_bottom = i_run & ~o_up & (o_count == '0);

endmodule // cpwm_updown

// file: rtl/cpwm_top.sv
// Complementary PWM channel with dead-time, double-buffered compares and Avalon-MM registers
//
// Summary of operation
// - High and low outputs drive one half-bridge as inverted PWM pair.
// - Each transition with nonzero half dead-time has a dead interval with neither output on, except when duty minus half dead-time reaches top.
// - Counter runs dual slope up to top and down, centre-aligned pulses.
// - High side clears on up-count match, sets on down-count match.
// - Low side sets on up-count match, clears on down-count match.
// - Equal compare values give exact complements with no dead interval.
// - High compare is duty minus half dead-time, low is duty plus it.
// - Dead interval is equal at rising and falling edges.
// - Both compare values switch at the same instant.
// - Written values sit in a buffer until the update point while running, and pass through each cycle while stopped.
// - Compares take effect at one fixed point of each cycle.
// - Overflow flag once per cycle, may raise a periodic interrupt.
// - Capture register may serve as counter top, beside fixed top.
// - In capture-top mode a capture event flags at the compare update.
// - Fixed top with different compares is 255.
// - Eight-bit phase-correct mode uses top 255.
// - Top 255 gives a cycle of 510 clocks.
`timescale 1ns/1ps
module cpwm_top
   import cpwm_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Avalon-MM slave
   input wire cpwm_avm_req_s i_avm,
   output logic o_avm_waitrequest,
   output logic [31:0] o_avm_readdata,
   // Half-bridge drive
   output logic o_high_side_drive_out,
   output logic o_low_side_drive_out,
   // Status
   output logic [W-1:0] o_updown_count_value,
   output logic o_irq
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic run;
   cpwm_top_e top_mode;
   logic [15:0] duty;
   logic [15:0] dead_half;
   logic [15:0] cap_top;
   logic [1:0] status;
   logic [1:0] mask;
   logic ack;
   logic wr_fire;
   logic rd_take;
   cpwm_cmp_s act;
   cpwm_cmp_s next_cmp;
   logic [15:0] top_act;
   logic [15:0] next_top;
   logic [16:0] lo_sum;
   logic [15:0] hi_diff;
   logic [W-1:0] count;
   logic up;
   logic at_top;
   logic at_bottom;
   logic [1:0] events;
   logic [1:0] w1c;
   logic [31:0] next_rdata;

   // ----------------------------------------
   // Byte-lane merge
   // ----------------------------------------
   function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [15:0] res;
      res = old;
      for (int b = 0; b < 2; b++)
      begin
         if (be[b])
         begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   // One wait state: every access answers on its second cycle
   assign o_avm_waitrequest = (i_avm.read | i_avm.write) & ~ack;
   assign wr_fire = i_avm.write & ack;
   assign rd_take = i_avm.read & ~ack;

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ack <= 1'b0;
      end
      else
      begin
         ack <= (i_avm.read | i_avm.write) & ~ack;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         run <= 1'b0;
         top_mode <= CPWM_TOP_FIXED8;
      end
      else if (wr_fire && i_avm.address == `CPWM_ADDR_CTRL && i_avm.byteenable[0])
      begin
         run <= i_avm.writedata[`CPWM_CTRL_RUN];
         top_mode <= i_avm.writedata[`CPWM_CTRL_CAPTOP] ? CPWM_TOP_CAPTURE : CPWM_TOP_FIXED8;
      end
   end

   // Buffers only; the active pair changes at top, or on every cycle while stopped
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         duty <= `CPWM_DUTY_RST;
         dead_half <= `CPWM_DEAD_RST;
         cap_top <= `CPWM_CAPTOP_RST;
      end
      else if (wr_fire)
      begin
         case (i_avm.address)
            `CPWM_ADDR_DUTY: duty <= be_merge(duty, i_avm.writedata, i_avm.byteenable);
            `CPWM_ADDR_DEAD: dead_half <= be_merge(dead_half, i_avm.writedata, i_avm.byteenable);
            `CPWM_ADDR_CAPTOP: cap_top <= be_merge(cap_top, i_avm.writedata, i_avm.byteenable);
            default: duty <= duty;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         mask <= 2'h0;
      end
      else if (wr_fire && i_avm.address == `CPWM_ADDR_MASK && i_avm.byteenable[0])
      begin
         mask <= i_avm.writedata[1:0];
      end
   end

   // ----------------------------------------
   // Buffered compare pair
   // ----------------------------------------
   always_comb
   begin
      if (top_mode == CPWM_TOP_CAPTURE)
      begin
         next_top = (cap_top < `CPWM_TOP_MIN) ? `CPWM_TOP_MIN : cap_top;
      end
      else
      begin
         next_top = `CPWM_TOP8;
      end
      hi_diff = (duty > dead_half) ? duty - dead_half : 16'h0000;
      lo_sum = {1'b0, duty} + {1'b0, dead_half};
      // Clamp guards the pair even if software oversteps the range
      next_cmp.hi = (hi_diff > next_top) ? next_top : hi_diff;
      next_cmp.lo = (lo_sum > {1'b0, next_top}) ? next_top : lo_sum[15:0];
   end

   // ----------------------------------------
   // Active compares and top, loaded together
   // ----------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         act <= '0;
         top_act <= `CPWM_TOP8;
      end
      else if (!run || at_top)
      begin
         act <= next_cmp;
         top_act <= next_top;
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   cpwm_updown #(
      .W(W)
   ) u_count (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_run(run),
      .i_top(top_act[W-1:0]),
      .o_count(count),
      .o_up(up),
      .o_at_top(at_top),
      .o_at_bottom(at_bottom)
   );

   assign o_updown_count_value = count;

   // ----------------------------------------
   // Drive outputs
   // ----------------------------------------
   // Level compare equals the match behaviour on both slopes; idle keeps both switches off
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_high_side_drive_out <= 1'b0;
         o_low_side_drive_out <= 1'b0;
      end
      else
      begin
         o_high_side_drive_out <= run & (16'(count) < act.hi);
         o_low_side_drive_out <= run & (16'(count) >= act.lo);
      end
   end

   // ----------------------------------------
   // Status and interrupt
   // ----------------------------------------
   assign events[`CPWM_ST_OVF] = at_bottom;
   assign events[`CPWM_ST_CAP] = at_top & (top_mode == CPWM_TOP_CAPTURE);
   assign w1c = (wr_fire && i_avm.address == `CPWM_ADDR_STATUS && i_avm.byteenable[0]) ? i_avm.writedata[1:0] : 2'h0;

   // Set beats a simultaneous write-one clear
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         status <= 2'h0;
      end
      else
      begin
         status <= (status & ~w1c) | events;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_irq <= 1'b0;
      end
      else
      begin
         o_irq <= |(status & mask);
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (i_avm.address)
         `CPWM_ADDR_CTRL:
         begin
            next_rdata[`CPWM_CTRL_RUN] = run;
            next_rdata[`CPWM_CTRL_CAPTOP] = (top_mode == CPWM_TOP_CAPTURE);
         end
         `CPWM_ADDR_DUTY: next_rdata[15:0] = duty;
         `CPWM_ADDR_DEAD: next_rdata[15:0] = dead_half;
         `CPWM_ADDR_CAPTOP: next_rdata[15:0] = cap_top;
         `CPWM_ADDR_STATUS: next_rdata[1:0] = status;
         `CPWM_ADDR_MASK: next_rdata[1:0] = mask;
         `CPWM_ADDR_COUNT:
         begin
            next_rdata[15:0] = 16'(count);
            next_rdata[`CPWM_COUNT_UP] = up;
         end
         `CPWM_ADDR_ACTIVE: next_rdata = {act.lo, act.hi};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_avm_readdata <= 32'h0000_0000;
      end
      else if (rd_take)
      begin
         o_avm_readdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Assertion helpers
   // ----------------------------------------
   logic [15:0] per_cnt;
   logic per_valid;

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         per_cnt <= 16'h0000;
         per_valid <= 1'b0;
      end
      else if (!run)
      begin
         per_cnt <= 16'h0000;
         per_valid <= 1'b0;
      end
      else if (at_bottom)
      begin
         per_cnt <= 16'h0000;
         per_valid <= (top_act == `CPWM_TOP8);
      end
      else
      begin
         per_cnt <= per_cnt + 16'h0001;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_no_shoot_through: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !(o_high_side_drive_out && o_low_side_drive_out))
      else $error("both half-bridge switches on");

   a_cmp_load_top: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (run && at_top) |=> (act == $past(next_cmp)))
      else $error("compare pair not loaded at top");

   a_cmp_hold_mid: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (run && !at_top && $past(run)) |=> $stable(act))
      else $error("active compare changed away from top");

   a_ovf_at_bottom: assert property (@(posedge i_core_clk) disable iff (i_rst)
      at_bottom |=> status[`CPWM_ST_OVF])
      else $error("overflow flag missed at bottom");

   a_cap_evt_top: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (at_top && top_mode == CPWM_TOP_CAPTURE) |=> (status[`CPWM_ST_CAP] && act == $past(next_cmp)))
      else $error("capture event not with compare update");

   a_period_fixed: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (at_bottom && per_valid && top_act == `CPWM_TOP8) |-> (per_cnt == 16'(`CPWM_PERIOD8 - 1)))
      else $error("fixed-top cycle is not 510 clocks");

   a_hs_up_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (run && up && 16'(count) == act.hi && $stable(act)) |=> !o_high_side_drive_out)
      else $error("high side not cleared on up match");

   a_ls_up_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (run && up && 16'(count) == act.lo && $stable(act)) |=> o_low_side_drive_out)
      else $error("low side not set on up match");

   a_equal_complement: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (run && act.hi == act.lo && $past(run)) |=> (o_high_side_drive_out != o_low_side_drive_out))
      else $error("equal compares not complementary");

   a_turn_at_top: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (run && at_top && $stable(run) && top_act <= `CPWM_TOP8) |=> (!up ##[1:1000] up))
      else $error("counter did not turn at top and return");

   a_irq_level: assert property (@(posedge i_core_clk) disable iff (i_rst)
      |(status & mask) |=> o_irq)
      else $error("unmasked flag without interrupt");

   a_bus_answer: assert property (@(posedge i_core_clk) disable iff (i_rst)
      ((i_avm.read || i_avm.write) && !ack) |=> ((i_avm.read || i_avm.write) |-> !o_avm_waitrequest))
      else $error("bus answer later than one wait state");

endmodule // cpwm_top

// file: sim/cpwm_bridge_model.sv
// Half-bridge model that watches the complementary gate pair
`timescale 1ns/1ps
module cpwm_bridge_model (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Window control and gates
   input wire logic i_clear,
   input wire logic i_high_gate,
   input wire logic i_low_gate,
   // Observed figures
   output logic [15:0] o_high_cycles,
   output logic [15:0] o_low_cycles,
   output logic [15:0] o_dead_cycles,
   output logic [15:0] o_dead_min,
   output logic [15:0] o_dead_max,
   output logic o_shoot
);
   logic [15:0] run_len;
   logic dead;

   assign dead = !i_high_gate && !i_low_gate;

   // ----------------------------------------
   // Switch bookkeeping
   // ----------------------------------------
   // Shoot-through is sticky so a one-cycle overlap is never lost
   always @(posedge i_core_clk)
   begin
      if (i_rst || i_clear)
      begin
         o_high_cycles <= 16'h0000;
         o_low_cycles <= 16'h0000;
         o_dead_cycles <= 16'h0000;
         o_dead_min <= 16'hffff;
         o_dead_max <= 16'h0000;
         o_shoot <= 1'b0;
         run_len <= 16'h0000;
      end
      else
      begin
         o_high_cycles <= o_high_cycles + 16'(i_high_gate);
         o_low_cycles <= o_low_cycles + 16'(i_low_gate);
         o_dead_cycles <= o_dead_cycles + 16'(dead);
         if (i_high_gate && i_low_gate)
            o_shoot <= 1'b1;
         run_len <= dead ? run_len + 16'h0001 : 16'h0000;
         // Runs are recorded when they end, a run cut by the window opening counts only its part after the clear
         if (!dead && run_len != 16'h0000)
         begin
            if (run_len < o_dead_min)
               o_dead_min <= run_len;
            if (run_len > o_dead_max)
               o_dead_max <= run_len;
         end
      end
   end
endmodule // cpwm_bridge_model

// file: sim/tb_top.sv
// Self-checking bench for the complementary PWM channel
`timescale 1ns/1ps
`include "cpwm_defines.svh"
module tb_top
   import cpwm_pkg::*;
;
   logic clk;
   logic rst;
   cpwm_avm_req_s avm;
   logic wait_req;
   logic [31:0] rdata;
   logic hi_drv;
   logic lo_drv;
   logic [15:0] count;
   logic irq;
   logic clr;
   logic [15:0] m_hi;
   logic [15:0] m_lo;
   logic [15:0] m_dead;
   logic [15:0] m_dmin;
   logic [15:0] m_dmax;
   logic m_shoot;
   int failures;
   int n_compared;
   int per;
   logic [15:0] peak;
   logic [31:0] q;

   cpwm_top #(.W(16)) cpwm_top_i (
      .i_core_clk(clk), .i_rst(rst), .i_avm(avm), .o_avm_waitrequest(wait_req),
      .o_avm_readdata(rdata), .o_high_side_drive_out(hi_drv), .o_low_side_drive_out(lo_drv),
      .o_updown_count_value(count), .o_irq(irq));

   cpwm_bridge_model cpwm_bridge_model_i (
      .i_core_clk(clk), .i_rst(rst), .i_clear(clr), .i_high_gate(hi_drv), .i_low_gate(lo_drv),
      .o_high_cycles(m_hi), .o_low_cycles(m_lo), .o_dead_cycles(m_dead),
      .o_dead_min(m_dmin), .o_dead_max(m_dmax), .o_shoot(m_shoot));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic give_up(input string what);
      failures++;
      $display("Error %s expected completion seen timeout", what);
      complete_run();
   endtask

   // ----------------------------------------
   // Bus and timing helpers
   // ----------------------------------------
   // Request held until waitrequest is sampled low; one idle edge after release
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avm.read <= rd;
      avm.write <= !rd;
      avm.address <= a;
      avm.writedata <= d;
      avm.byteenable <= 4'hf;
      do
      begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 100);
      if (n >= 100)
         give_up("waitrequest");
      q = rdata;
      avm.read <= 1'b0;
      avm.write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      bus(1'b1, a, 32'h0000_0000);
      check(name, exp, q);
   endtask

   task automatic wait_count(input logic [15:0] v);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (count !== v && n < 2000);
      if (n >= 2000)
         give_up("count");
   endtask

   // Cycles from one bottom to the next, and the highest count seen
   task automatic period();
      int n;
      n = 0;
      peak = 16'h0000;
      wait_count(16'h0000);
      do
      begin
         @(posedge clk);
         n++;
         if (count > peak)
            peak = count;
      end while (count !== 16'h0000 && n < 2000);
      per = n;
   endtask

   // One full 510-cycle window of the bridge model, opened at bottom
   task automatic window();
      wait_count(16'h0000);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (511) @(posedge clk);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      avm = '0;
      clr = 1'b0;
      failures = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      check("reset pins", 32'h0, {29'h0, hi_drv, lo_drv, irq});
      rd_chk(`CPWM_ADDR_CTRL, 32'h0, "ctrl");
      rd_chk(`CPWM_ADDR_DUTY, 32'h80, "duty");
      rd_chk(`CPWM_ADDR_DEAD, 32'h0, "dead");
      rd_chk(`CPWM_ADDR_CAPTOP, 32'hff, "captop");
      rd_chk(`CPWM_ADDR_STATUS, 32'h0, "status");
      rd_chk(`CPWM_ADDR_MASK, 32'h0, "mask");
      rd_chk(8'h20, 32'h0, "unmapped");
      // Duty 128, half dead-time 4, kept inside 0..top
      wr(`CPWM_ADDR_DUTY, 32'h80);
      wr(`CPWM_ADDR_DEAD, 32'h4);
      rd_chk(`CPWM_ADDR_ACTIVE, 32'h0084_007c, "active pair");
      wr(`CPWM_ADDR_CTRL, 32'h1);
      period();
      check("period", 32'd510, per);
      check("peak", 32'd255, {16'h0, peak});
      window();
      check("high cycles", 32'd247, {16'h0, m_hi});
      check("low cycles", 32'd247, {16'h0, m_lo});
      check("dead cycles", 32'd16, {16'h0, m_dead});
      check("dead min", 32'd8, {16'h0, m_dmin});
      check("dead max", 32'd8, {16'h0, m_dmax});
      check("overlap", 32'h0, {31'h0, m_shoot});
      // Overflow flag and its interrupt
      wait_count(16'h0005);
      rd_chk(`CPWM_ADDR_STATUS, 32'h1, "overflow flag");
      check("irq masked", 32'h0, {31'h0, irq});
      wr(`CPWM_ADDR_MASK, 32'h1);
      repeat (2) @(posedge clk);
      check("irq set", 32'h1, {31'h0, irq});
      wr(`CPWM_ADDR_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      check("irq cleared", 32'h0, {31'h0, irq});
      rd_chk(`CPWM_ADDR_STATUS, 32'h0, "status cleared");
      // New compares wait in the buffer until top
      wr(`CPWM_ADDR_DEAD, 32'h0);
      rd_chk(`CPWM_ADDR_ACTIVE, 32'h0084_007c, "active held");
      wait_count(16'h00ff);
      repeat (3) @(posedge clk);
      rd_chk(`CPWM_ADDR_ACTIVE, 32'h0080_0080, "active loaded");
      window();
      check("equal high", 32'd255, {16'h0, m_hi});
      check("equal low", 32'd255, {16'h0, m_lo});
      check("equal dead", 32'd0, {16'h0, m_dead});
      // Capture register as top
      wr(`CPWM_ADDR_CAPTOP, 32'd100);
      wr(`CPWM_ADDR_CTRL, 32'h3);
      wait_count(16'h00ff);
      period();
      check("capture period", 32'd200, per);
      wr(`CPWM_ADDR_STATUS, 32'h3);
      wait_count(16'd100);
      repeat (2) @(posedge clk);
      rd_chk(`CPWM_ADDR_STATUS, 32'h2, "capture flag");
      // Stopped channel leaves both switches off
      wr(`CPWM_ADDR_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      check("stopped pins", 32'h0, {30'h0, hi_drv, lo_drv});
      rd_chk(`CPWM_ADDR_COUNT, 32'h0001_0000, "stopped count");
      complete_run();
   end
endmodule // tb_top
